// File: rtl/sensorless_bldc_commutation_sequencer.sv
// Six-state sensorless commutation sequencer with adaptive delay and tacho output
//
// Operation
// - each state drives two phases, one high one low, third floats.
// - states cycle 1..6 with the fixed drive table, then wrap to 1.
// - zero-crossing input is the comparator of the floating phase.
// - zero-crossing starts delay; delay end advances to next state.
// - primary timer counts up from commutation to zero-crossing, paused during flyback pulse.
// - primary timer then counts down at double rate to time the delay.
// - saturated primary timer gives fixed full-range delay at low speed.
// - repeat timer counts up and down equally, reproducing the delay.
// - speed output is open collector at half commutation frequency.
// - marker pulse is multiplexed onto the shared speed output.
// - start oscillator issues commutation pulses without zero-crossings.
// - every commutation resets the start oscillator.
// - a start pulse advances the state like a regular commutation.
// - start oscillator period is one full up-and-down ramp, configurable.
// - timing function sequences internal delays and reverse detection.
// - watchdog runs past short segment only while EMF polarity wrong.
// - each zero-crossing toggles the tacho level.
// - after sensed marker, one tacho pulse gets a short low time.
`timescale 1ns/1ps
`include "bldc_params.svh"
module sensorless_bldc_commutation_sequencer #(
	parameter int TICK_DIV = `TICK_DIV,
	parameter int CD_LIMIT = `CD_LIMIT,
	parameter int DC_LIMIT = `DC_LIMIT,
	parameter int ST_HALF_TICKS = `ST_HALF_TICKS,
	parameter int WD_SHORT_TICKS = `WD_SHORT_TICKS,
	parameter int WD_LIMIT_TICKS = `WD_LIMIT_TICKS
) (
	input wire logic sys_clk_i,
	input wire logic reset_n_i,
	input wire logic [2:0] emf_cmp_i,
	input wire logic [2:0] flyback_i,
	input wire logic phase_marker_input_i,
	output logic phase_out_a_o,
	output logic phase_out_a_oe_o,
	output logic phase_out_b_o,
	output logic phase_out_b_oe_o,
	output logic phase_out_c_o,
	output logic phase_out_c_oe_o,
	output logic speed_marker_output_o,
	output logic speed_marker_output_oe_o,
	output bldc_pkg::comm_state_t state_o,
	output logic startup_mode_o,
	output logic reverse_detect_o
);
	import bldc_pkg::*;

	localparam int DW = `DLY_WIDTH;
	localparam int SW = `ST_WIDTH;
	localparam int WW = `WD_WIDTH;
	localparam int PW = `PG_WIDTH;
	localparam logic [SW-1:0] ST_LAST = SW'(2 * ST_HALF_TICKS - 1);
	localparam logic [WW-1:0] WD_SHORT = WW'(WD_SHORT_TICKS);
	localparam logic [WW-1:0] WD_LIMIT = WW'(WD_LIMIT_TICKS);
	localparam logic [PW-1:0] PG_LAST = PW'(`PG_LOW_CYC - 1);

	if (2 * ST_HALF_TICKS > (1 << SW) || ST_HALF_TICKS < 1 ||
		WD_LIMIT_TICKS >= (1 << WW) || WD_SHORT_TICKS >= WD_LIMIT_TICKS ||
		`PG_LOW_CYC > (1 << PW) || CD_LIMIT >= (1 << DW) ||
		DC_LIMIT >= (1 << DW)) begin : g_bad_param
		$error("sequencer: timing parameter out of range");
	end

	comm_state_t state_ff;
	dly_phase_t dly_ff;
	logic tick;
	logic half_ff;
	logic [1:0] fidx;
	logic sel_cmp;
	logic post_lvl;
	logic blank;
	logic armed_ff;
	logic zc;
	logic commute;
	logic start_pulse;
	logic startup_ff;
	logic [SW-1:0] st_cnt_ff;
	logic [WW-1:0] wd_cnt_ff;
	logic wd_run_ff;
	logic wd_timeout;
	logic reverse_ff;
	logic tacho_signal_ff;
	logic pm_prev_ff;
	logic pg_arm_ff;
	logic pg_short_ff;
	logic pg_rel_ff;
	logic [PW-1:0] pg_cnt_ff;
	logic speed_oe_ff;
	logic [2:0] out_lvl_ff;
	logic [2:0] out_oe_ff;

	delay_if #(.WIDTH(DW)) cd ();
	delay_if #(.WIDTH(DW)) dc ();

	// One base tick feeds every timer except the marker pulse counter, which counts system clocks
	tick_divider #(.DIV(TICK_DIV)) u_tick (
		.sys_clk_i(sys_clk_i),
		.reset_n_i(reset_n_i),
		.tick_o(tick)
	);

	updown_timer #(.WIDTH(DW), .LIMIT(CD_LIMIT)) u_primary_delay_timer (
		.sys_clk_i(sys_clk_i),
		.reset_n_i(reset_n_i),
		.tmr(cd)
	);

	updown_timer #(.WIDTH(DW), .LIMIT(DC_LIMIT)) u_repeat_delay_timer (
		.sys_clk_i(sys_clk_i),
		.reset_n_i(reset_n_i),
		.tmr(dc)
	);

	assign fidx = float_phase(state_ff);
	assign sel_cmp = emf_cmp_i[fidx];
	// Odd states see a rising crossing, even states a falling one
	assign post_lvl = state_ff[0];
	assign blank = (dly_ff == DLY_MEASURE) && !dc.empty;
	assign zc = armed_ff && (dly_ff == DLY_MEASURE) && (sel_cmp == post_lvl);
	assign start_pulse = tick && (st_cnt_ff == ST_LAST);
	assign commute = start_pulse || ((dly_ff == DLY_COMMIT) && cd.empty);
	assign wd_timeout = wd_run_ff && tick && (wd_cnt_ff == WD_LIMIT);

	// Half-rate enable makes the up count half the down count
	always_ff @(posedge sys_clk_i) begin
		if (!reset_n_i) begin
			half_ff <= 1'b0;
		end else if (tick) begin
			half_ff <= !half_ff;
		end
	end

	assign cd.clr = commute;
	assign cd.up = (dly_ff == DLY_MEASURE) && tick && half_ff && !flyback_i[fidx];
	assign cd.dn = (dly_ff == DLY_COMMIT) && tick;
	assign dc.clr = zc;
	assign dc.up = (dly_ff == DLY_COMMIT) && tick;
	assign dc.dn = (dly_ff == DLY_MEASURE) && tick;

	always_ff @(posedge sys_clk_i) begin
		if (!reset_n_i) begin
			state_ff <= ST1;
		end else if (commute) begin
			state_ff <= next_state(state_ff);
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!reset_n_i || commute) begin
			dly_ff <= DLY_MEASURE;
		end else if (zc) begin
			dly_ff <= DLY_COMMIT;
		end
	end

	// Crossing accepted only after the repeat delay and short watchdog segment,
	// and only once the EMF has first shown the pre-crossing polarity
	always_ff @(posedge sys_clk_i) begin
		if (!reset_n_i || commute || zc) begin
			armed_ff <= 1'b0;
		end else if (!blank && !(wd_run_ff && wd_cnt_ff < WD_SHORT) && sel_cmp != post_lvl) begin
			armed_ff <= 1'b1;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!reset_n_i || commute) begin
			st_cnt_ff <= '0;
		end else if (tick) begin
			st_cnt_ff <= st_cnt_ff + SW'(1);
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!reset_n_i || wd_timeout) begin
			startup_ff <= 1'b1;
		end else if (commute && !start_pulse) begin
			startup_ff <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!reset_n_i) begin
			wd_cnt_ff <= '0;
			wd_run_ff <= 1'b0;
		end else if (commute) begin
			wd_cnt_ff <= '0;
			wd_run_ff <= 1'b1;
		end else if (wd_run_ff && tick) begin
			if (wd_cnt_ff < WD_SHORT) begin
				wd_cnt_ff <= wd_cnt_ff + WW'(1);
			end else if (sel_cmp != post_lvl || wd_cnt_ff == WD_LIMIT) begin
				wd_cnt_ff <= '0;
				wd_run_ff <= 1'b0;
			end else begin
				wd_cnt_ff <= wd_cnt_ff + WW'(1);
			end
		end
	end

	// Wrong polarity held for the full interval means reverse rotation
	always_ff @(posedge sys_clk_i) begin
		if (!reset_n_i) begin
			reverse_ff <= 1'b0;
		end else begin
			reverse_ff <= wd_timeout;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!reset_n_i) begin
			tacho_signal_ff <= 1'b1;
		end else if (zc) begin
			tacho_signal_ff <= !tacho_signal_ff;
		end
	end

	// Marker picks the falling crossing on phase c (state 2)
	always_ff @(posedge sys_clk_i) begin
		if (!reset_n_i) begin
			pm_prev_ff <= 1'b0;
			pg_arm_ff <= 1'b0;
		end else begin
			pm_prev_ff <= phase_marker_input_i;
			if (phase_marker_input_i && !pm_prev_ff) begin
				pg_arm_ff <= 1'b1;
			end else if (zc && state_ff == ST2 && tacho_signal_ff) begin
				pg_arm_ff <= 1'b0;
			end
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!reset_n_i) begin
			pg_short_ff <= 1'b0;
			pg_rel_ff <= 1'b0;
			pg_cnt_ff <= '0;
		end else if (zc) begin
			pg_short_ff <= pg_arm_ff && state_ff == ST2 && tacho_signal_ff;
			pg_rel_ff <= 1'b0;
			pg_cnt_ff <= '0;
		end else if (pg_short_ff) begin
			if (pg_cnt_ff == PG_LAST) begin
				pg_short_ff <= 1'b0;
				pg_rel_ff <= 1'b1;
			end else begin
				pg_cnt_ff <= pg_cnt_ff + PW'(1);
			end
		end
	end

	// Open collector: pull low while tacho is low, unless the marker pulse ended
	always_ff @(posedge sys_clk_i) begin
		if (!reset_n_i) begin
			speed_oe_ff <= 1'b0;
		end else begin
			speed_oe_ff <= !tacho_signal_ff && !pg_rel_ff;
		end
	end

	// Drivers follow the next state so pins and state change together
	for (genvar i = 0; i < 3; i++) begin : g_phase
		always_ff @(posedge sys_clk_i) begin
			if (!reset_n_i) begin
				out_lvl_ff[i] <= phase_drive(ST1, 2'(i)) == DRV_H;
				out_oe_ff[i] <= phase_drive(ST1, 2'(i)) != DRV_Z;
			end else begin
				out_lvl_ff[i] <= phase_drive(commute ? next_state(state_ff) : state_ff,
					2'(i)) == DRV_H;
				out_oe_ff[i] <= phase_drive(commute ? next_state(state_ff) : state_ff,
					2'(i)) != DRV_Z;
			end
		end
	end

	assign phase_out_a_o = out_lvl_ff[0];
	assign phase_out_a_oe_o = out_oe_ff[0];
	assign phase_out_b_o = out_lvl_ff[1];
	assign phase_out_b_oe_o = out_oe_ff[1];
	assign phase_out_c_o = out_lvl_ff[2];
	assign phase_out_c_oe_o = out_oe_ff[2];
	assign speed_marker_output_o = 1'b0;
	assign speed_marker_output_oe_o = speed_oe_ff;
	assign state_o = state_ff;
	assign startup_mode_o = startup_ff;
	assign reverse_detect_o = reverse_ff;

	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!reset_n_i);

	property p_two_driven;
		$past(reset_n_i) |-> $countones(out_oe_ff) == 2 && $countones(out_lvl_ff) == 1
			&& !out_oe_ff[float_phase(state_ff)];
	endproperty
	a_two_driven: assert property (p_two_driven) else $error("drive pattern wrong");

	property p_sequence;
		commute |=> state_ff == next_state($past(state_ff));
	endproperty
	a_sequence: assert property (p_sequence) else $error("state did not advance");

	property p_select;
		sel_cmp == emf_cmp_i[float_phase(state_ff)] && !out_oe_ff[fidx];
	endproperty
	a_select: assert property (p_select) else $error("wrong comparator");

	// A start pulse landing on a crossing wins, so the delay is not started then
	property p_zc_starts;
		zc && !commute |=> dly_ff == DLY_COMMIT && dc.empty;
	endproperty
	a_zc_starts: assert property (p_zc_starts) else $error("delay not started");

	property p_flyback_pause;
		flyback_i[fidx] && !commute |=> cd.cnt == $past(cd.cnt) || dly_ff == DLY_COMMIT;
	endproperty
	a_flyback_pause: assert property (p_flyback_pause) else $error("count in flyback");

	property p_half_rate;
		cd.up |-> half_ff && tick ##1 !cd.up;
	endproperty
	a_half_rate: assert property (p_half_rate) else $error("up rate too fast");

	property p_osc_reset;
		commute |=> st_cnt_ff == '0;
	endproperty
	a_osc_reset: assert property (p_osc_reset) else $error("oscillator not reset");

	property p_tacho;
		zc |=> tacho_signal_ff != $past(tacho_signal_ff);
	endproperty
	a_tacho: assert property (p_tacho) else $error("tacho not toggled");

	property p_wd_clear;
		wd_timeout |=> wd_cnt_ff == '0 && startup_ff && reverse_ff;
	endproperty
	a_wd_clear: assert property (p_wd_clear) else $error("watchdog not cleared");

endmodule : sensorless_bldc_commutation_sequencer

// File: inc/bldc_params.svh
// Timing counts, reset values and limits for the commutation sequencer
`ifndef BLDC_PARAMS_SVH
`define BLDC_PARAMS_SVH

`define CLK_MHZ 25
// Base timer tick divider, in system clocks
`define TICK_DIV 25
// Full-range counts of the two delay timers, in ticks
`define CD_LIMIT 4095
`define DC_LIMIT 4095
`define DLY_WIDTH 12
// Start oscillator half ramp, in ticks
`define ST_HALF_TICKS 250000
`define ST_WIDTH 20
// Watchdog short segment and full interval, in ticks
`define WD_SHORT_TICKS 20
`define WD_LIMIT_TICKS 380
`define WD_WIDTH 12
// Marker pulse low time
`define PG_LOW_NS 18000
`define PG_LOW_CYC ((`PG_LOW_NS * `CLK_MHZ) / 1000)
`define PG_WIDTH 10
// Reset state code
`define STATE_RESET 3'h1

`endif

// File: inc/bldc_pkg.sv
// Types and lookup functions for the commutation sequencer
package bldc_pkg;

	typedef enum logic [2:0] {
		ST1 = 3'h1,
		ST2 = 3'h2,
		ST3 = 3'h3,
		ST4 = 3'h4,
		ST5 = 3'h5,
		ST6 = 3'h6
	} comm_state_t;

	typedef enum logic [1:0] {
		DRV_Z = 2'h0,
		DRV_H = 2'h1,
		DRV_L = 2'h2
	} drive_t;

	typedef enum logic [0:0] {
		DLY_MEASURE = 1'h0,
		DLY_COMMIT = 1'h1
	} dly_phase_t;

	function automatic comm_state_t next_state(comm_state_t s);
		unique case (s)
			ST1: next_state = ST2;
			ST2: next_state = ST3;
			ST3: next_state = ST4;
			ST4: next_state = ST5;
			ST5: next_state = ST6;
			default: next_state = ST1;
		endcase
	endfunction : next_state

	// Index of the floating phase: 0 = a, 1 = b, 2 = c
	function automatic logic [1:0] float_phase(comm_state_t s);
		unique case (s)
			ST1, ST4: float_phase = 2'h0;
			ST3, ST6: float_phase = 2'h1;
			default: float_phase = 2'h2;
		endcase
	endfunction : float_phase

	function automatic drive_t phase_drive(comm_state_t s, logic [1:0] ph);
		drive_t t [3];
		unique case (s)
			ST1: t = '{DRV_Z, DRV_L, DRV_H};
			ST2: t = '{DRV_H, DRV_L, DRV_Z};
			ST3: t = '{DRV_H, DRV_Z, DRV_L};
			ST4: t = '{DRV_Z, DRV_H, DRV_L};
			ST5: t = '{DRV_L, DRV_H, DRV_Z};
			default: t = '{DRV_L, DRV_Z, DRV_H};
		endcase
		phase_drive = t[ph];
	endfunction : phase_drive

endpackage : bldc_pkg

// File: inc/delay_if.sv
// Control and status of one up/down delay timer
`timescale 1ns/1ps
interface delay_if #(parameter int WIDTH = 12);
	logic clr;
	logic up;
	logic dn;
	logic [WIDTH-1:0] cnt;
	logic full;
	logic empty;
	modport ctrl (output clr, output up, output dn, input cnt, input full, input empty);
	modport timer (input clr, input up, input dn, output cnt, output full, output empty);
endinterface : delay_if

// File: rtl/tick_divider.sv
// Clock-enable tick generator for the timer counters
`timescale 1ns/1ps
module tick_divider #(
	parameter int DIV = 25
) (
	input wire logic sys_clk_i,
	input wire logic reset_n_i,
	output logic tick_o
);
	localparam int W = (DIV > 1) ? $clog2(DIV) : 1;
	localparam logic [W-1:0] LAST = W'(DIV - 1);

	logic [W-1:0] div_ff;

	if (DIV < 1) begin : g_bad_div
		$error("tick_divider: DIV must be at least 1");
	end

	always_ff @(posedge sys_clk_i) begin
		if (!reset_n_i || div_ff == LAST) begin
			div_ff <= '0;
		end else begin
			div_ff <= div_ff + W'(1);
		end
	end

	assign tick_o = reset_n_i && (div_ff == LAST);
endmodule : tick_divider

// File: rtl/updown_timer.sv
// Saturating up/down counter standing in for a ramp capacitor
`timescale 1ns/1ps
module updown_timer #(
	parameter int WIDTH = 12,
	parameter int LIMIT = 4095
) (
	input wire logic sys_clk_i,
	input wire logic reset_n_i,
	delay_if.timer tmr
);
	localparam logic [WIDTH-1:0] LIM = WIDTH'(LIMIT);

	logic [WIDTH-1:0] cnt_ff;

	if (LIMIT < 1 || LIMIT >= (1 << WIDTH)) begin : g_bad_limit
		$error("updown_timer: LIMIT does not fit WIDTH");
	end

	// Saturates at the limit so a slow motor yields the full-range delay
	always_ff @(posedge sys_clk_i) begin
		if (!reset_n_i || tmr.clr) begin
			cnt_ff <= '0;
		end else if (tmr.up && cnt_ff != LIM) begin
			cnt_ff <= cnt_ff + WIDTH'(1);
		end else if (tmr.dn && cnt_ff != '0) begin
			cnt_ff <= cnt_ff - WIDTH'(1);
		end
	end

	assign tmr.cnt = cnt_ff;
	assign tmr.full = (cnt_ff == LIM);
	assign tmr.empty = (cnt_ff == '0);
endmodule : updown_timer

// File: tb/motor_model.sv
// Behavioural motor: three windings with back-EMF comparators and flyback pulses
`timescale 1ns/1ps
module motor_model (
	input wire logic sys_clk_i,
	input wire logic reset_n_i,
	input wire logic [2:0] drive_i,
	input wire logic [2:0] oe_i,
	input wire logic [1:0] mode_i,
	input wire logic [8:0] zc_delay_i,
	input wire logic [8:0] fb_len_i,
	output logic [2:0] emf_cmp_o,
	output logic [2:0] flyback_o,
	output logic crossed_o
);
	logic [2:0] oe_ff;
	logic [8:0] age_ff;
	int f;
	logic pre;
	logic post_now;

	// Age restarts whenever the driven pattern changes
	always_ff @(posedge sys_clk_i) begin
		oe_ff <= oe_i;
		if (!reset_n_i || oe_i != oe_ff)
			age_ff <= 9'h0;
		else if (age_ff != 9'h1ff)
			age_ff <= age_ff + 9'h1;
	end

	always_comb begin
		f = oe_i[0] ? (oe_i[1] ? 2 : 1) : 0;
		// Rising crossing expected when the preceding phase sources
		pre = !drive_i[(f + 2) % 3];
		// Mode 0 still, 1 running, 2 turning backwards
		post_now = mode_i == 2'h2 || (mode_i == 2'h1 && age_ff >= zc_delay_i);
		// Driven phases show junk that changes every cycle until the age saturates
		emf_cmp_o = {3{age_ff[0]}} ^ 3'h5;
		flyback_o = 3'h0;
		flyback_o[f] = age_ff < fb_len_i;
		emf_cmp_o[f] = post_now ? !pre : pre;
		crossed_o = mode_i == 2'h1 && age_ff == zc_delay_i;
	end
endmodule : motor_model

// File: tb/tb_sensorless_bldc_commutation_sequencer.sv
// Self-checking bench: motor model runs the sequencer through start-up, run and reverse
`timescale 1ns/1ps
module tb_sensorless_bldc_commutation_sequencer;
	import bldc_pkg::*;
	localparam int ST_HALF = 300;
	// Marked low time: 18 us at a 40 ns clock
	localparam int PG_LOW = 450;
	localparam int LIM = 63;
	localparam int FB = 4;
	logic sys_clk, reset_n, marker;
	logic [1:0] mode;
	logic [8:0] zc_delay;
	logic [2:0] emf, flyback;
	wire [2:0] drv, oe;
	wire crossed, speed_oe, speed_lvl, startup, reverse;
	comm_state_t state;
	comm_state_t prev_state;
	logic prev_speed;
	int num_errors = 0;
	int checks = 0;
	int seed, exp_state, last_comm, zc_cyc, tog, revs, skip, exp_dly, oe_rise, marks;
	int cyc = 0;
	int comm_cnt = 0;
	logic [5:0] tbl [1:6] = '{6'h18, 6'h09, 6'h21, 6'h24, 6'h06, 6'h12};

	sensorless_bldc_commutation_sequencer #(.TICK_DIV(1), .CD_LIMIT(LIM), .DC_LIMIT(LIM),
		.ST_HALF_TICKS(ST_HALF), .WD_SHORT_TICKS(2), .WD_LIMIT_TICKS(20)) dut (
		.sys_clk_i(sys_clk), .reset_n_i(reset_n), .emf_cmp_i(emf), .flyback_i(flyback),
		.phase_marker_input_i(marker),
		.phase_out_a_o(drv[0]), .phase_out_a_oe_o(oe[0]),
		.phase_out_b_o(drv[1]), .phase_out_b_oe_o(oe[1]),
		.phase_out_c_o(drv[2]), .phase_out_c_oe_o(oe[2]),
		.speed_marker_output_o(speed_lvl), .speed_marker_output_oe_o(speed_oe),
		.state_o(state), .startup_mode_o(startup), .reverse_detect_o(reverse));

	motor_model motor (.sys_clk_i(sys_clk), .reset_n_i(reset_n), .drive_i(drv), .oe_i(oe),
		.mode_i(mode), .zc_delay_i(zc_delay), .fb_len_i(9'h4), .emf_cmp_o(emf),
		.flyback_o(flyback), .crossed_o(crossed));

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value %s expected %0h seen %0h", what, exp, seen);
		end
	endtask : check

	task automatic give_verdict();
		$display("checks %0d num_errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : give_verdict

	// Two bits per phase, a lowest: 0 floating, 1 sourcing, 2 sinking
	function automatic logic [5:0] code_of(input logic [2:0] d, input logic [2:0] e);
		for (int i = 0; i < 3; i++)
			code_of[2*i +: 2] = e[i] ? (d[i] ? 2'h1 : 2'h2) : 2'h0;
	endfunction : code_of

	task automatic do_reset();
		reset_n <= 1'b0;
		repeat (20) @(posedge sys_clk);
		@(negedge sys_clk);
		check("reset state", state, 1);
		check("reset phases", code_of(drv, oe), tbl[1]);
		check("reset flags", {speed_oe, startup, reverse}, 3'h2);
		exp_state = 1;
		prev_state = ST1;
		prev_speed = speed_oe;
		last_comm = cyc;
		@(posedge sys_clk);
		reset_n <= 1'b1;
	endtask : do_reset

	// First periods after a change mix old and new motor behaviour, so they are skipped
	task automatic run(input logic [1:0] m, input int d, input int n);
		int stop;
		@(posedge sys_clk);
		stop = comm_cnt + n;
		skip = (m == mode) ? 1 : 2;
		mode <= m;
		zc_delay <= d[8:0];
		exp_dly = (d - FB) / 2 < LIM ? (d - FB) / 2 : LIM;
		for (int i = 0; i < 4000 && comm_cnt < stop; i++)
			@(posedge sys_clk);
		check("commutations", comm_cnt >= stop, 1);
	endtask : run

	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end

	always @(posedge sys_clk) cyc++;

	always @(negedge sys_clk) begin
		if (reset_n === 1'b1) begin
			if (crossed)
				zc_cyc = cyc;
			if (speed_oe !== prev_speed) begin
				tog++;
				if (speed_oe === 1'b1)
					oe_rise = cyc;
				else if ((cyc - oe_rise) inside {[PG_LOW - 1:PG_LOW + 1]})
					marks++;
			end
			prev_speed = speed_oe;
			if (reverse === 1'b1) begin
				if (revs == 0 && mode == 2'h2 && skip == 0)
					check("reverse delay", (cyc - last_comm) inside {[18:26]}, 1);
				revs++;
			end
			if (state !== prev_state) begin
				exp_state = exp_state % 6 + 1;
				check("state", state, exp_state);
				check("phases", code_of(drv, oe), tbl[exp_state]);
				check("speed level", speed_lvl, 0);
				if (skip > 0)
					skip--;
				else if (mode == 2'h0) begin
					check("start period", (cyc - last_comm) inside {[2 * ST_HALF - 2:2 * ST_HALF + 2]}, 1);
					check("still tacho", tog, 0);
					check("start flag", startup, 1);
				end else if (mode == 2'h1) begin
					check("delay", (cyc - zc_cyc - exp_dly) inside {[-2:4]}, 1);
					check("tacho", tog, 1);
					check("start flag", startup, 0);
				end else begin
					check("reverse seen", revs > 0, 1);
					check("start flag", startup, 1);
				end
				last_comm = cyc;
				tog = 0;
				revs = 0;
				prev_state = state;
				comm_cnt++;
			end
		end
	end

	initial begin
		reset_n = 1'b0;
		marker = 1'b0;
		mode = 2'h0;
		zc_delay = 9'h28;
		seed = 24;
		do_reset();
		run(2'h0, 40, 3);
		for (int i = 0; i < 6; i++)
			run(2'h1, 40 + ($random(seed) & 31), 4);
		check("plain pulses", marks, 0);
		// Period must outlast the marked low time, or the next crossing cuts it
		marker <= 1'b1;
		run(2'h1, 400, 7);
		marker <= 1'b0;
		check("marked pulse", marks, 1);
		// Long period saturates the primary timer
		run(2'h1, 160, 4);
		run(2'h2, 160, 3);
		do_reset();
		give_verdict();
	end

	// Whole sequence needs about 10000 cycles
	initial begin
		repeat (20000) @(posedge sys_clk);
		num_errors++;
		give_verdict();
	end
endmodule : tb_sensorless_bldc_commutation_sequencer
